// [tb.sv]
/*
  Self-checking bench for the turn signal lamp logic.
  Assumes one evaluation tick every 40960 cycles; the slow wave phase is
  not predicted, so blink lamps are judged against each other.
*/
`timescale 1ns/10ps
module tb;
  import tsl_pkg::*;
  logic       clk;
  logic       rstn;
  logic [4:0] want;
  logic [4:0] sw;
  logic [5:0] lit;
  int         n_fail;
  int         n_tests;
  tsl_car car (.clk(clk), .want(want), .sw(sw), .lamp(lit), .lit());
  tsl_top dut (.clk(clk), .rstn(rstn), .left_turn(sw[0]), .right_turn(sw[1]),
    .brake(sw[2]), .hazard(sw[3]), .parking(sw[4]),
    .left_front_lamp(lit[0]), .right_front_lamp(lit[1]), .left_rear_lamp(lit[2]),
    .right_rear_lamp(lit[3]), .left_dash_lamp(lit[4]), .right_dash_lamp(lit[5]));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", what, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // Set switches, then sample mid-way into the next evaluation interval
  task automatic next_tick(input logic [4:0] w);
    @(negedge clk) want = w;
    repeat (TICK_CYCLES) @(negedge clk);
  endtask : next_tick
  task automatic t_reset_dark;
    want = 5'h1F;
    repeat (100) @(negedge clk);
    chk("lamps before first tick", 1'b0, |lit);
  endtask : t_reset_dark
  task automatic t_brake_left_park;
    next_tick(5'h15);
    chk("right rear brake", 1'b1, lit[3]);
    chk("right dash", 1'b0, lit[5]);
    chk("left front vs rear", lit[2], lit[0]);
    chk("left rear blink", lit[4] | lit[1], lit[2]);
  endtask : t_brake_left_park
  task automatic t_park_only;
    logic g;
    next_tick(5'h10);
    g = lit[0];
    chk("dash glow", 1'b0, lit[4] | lit[5]);
    chk("glow rear", g, lit[3]);
    next_tick(5'h10);
    chk("glow toggles", ~g, lit[1]);
  endtask : t_park_only
  task automatic t_hazard_brake;
    next_tick(5'h08);
    chk("hazard left", lit[4], lit[0]);
    chk("hazard right", lit[4], lit[5]);
    chk("hazard rear", lit[4], lit[3]);
    next_tick(5'h0C);
    chk("hazard brake rears", 1'b1, lit[2] & lit[3]);
    chk("hazard brake front", lit[5], lit[1]);
    next_tick(5'h00);
    chk("all idle", 1'b0, |lit);
  endtask : t_hazard_brake
  // Six ticks of work after a half-interval lead-in; the limit leaves about half an interval spare
  initial
  begin
    repeat (7 * TICK_CYCLES) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    want = 5'h00;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_reset_dark();
    repeat (TICK_CYCLES / 2) @(negedge clk);
    t_brake_left_park();
    t_park_only();
    t_hazard_brake();
    finish_test();
  end
endmodule : tb

// [tsl_car.sv]
/*
  Far side of the lamp logic: switch contacts and lamp bulbs.
  Assumes the bench sets the wanted switch pattern; contacts move on falling edges.
*/
`timescale 1ns/10ps
module tsl_car (
  input  wire logic       clk,  // System clock
  input  wire logic [4:0] want, // Pattern: left, right, brake, hazard, parking
  output logic      [4:0] sw,   // Switch contacts to the block
  input  wire logic [5:0] lamp, // Bulb drives from the block
  output logic      [5:0] lit   // Bulbs seen lit
);
  initial sw = 5'h00;
  // Contacts are active high levels, any combination allowed
  always @(negedge clk)
  begin
    sw <= want;
  end
  assign lit = lamp;
endmodule : tsl_car

// [tsl_pkg.sv]
/*
  Constants for the turn signal lamp logic: timing of the periodic
  evaluation tick, the blink divider and reset values.
  Assumes a 10 MHz system clock.
*/
package tsl_pkg;
  // System clock
  localparam int CLK_HZ          = 10_000_000;
  // Evaluation tick period in microseconds
  localparam int TICK_US         = 4096;
  localparam int TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICK_W          = 16;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // Divider reload; top bit gives about 0.999 s period
  localparam int DIV_W           = 8;
  localparam logic [DIV_W-1:0] DIV_RELOAD = 8'hF4;
  localparam logic [DIV_W-1:0] DIV_RESET  = 8'h00;
  localparam int FAST_BIT        = 0;
  localparam int SLOW_BIT        = 7;
  localparam int SYNC_STAGES     = 2;
endpackage : tsl_pkg

// [tsl_sync.sv]
/*
  Two flip-flop synchroniser for one switch input.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
module tsl_sync (
  input  wire logic clk,    // System clock
  input  wire logic rstn,   // Synchronised active low reset
  input  wire logic d,      // Asynchronous level
  output logic      q       // Synchronised level
);
  import tsl_pkg::*;
  logic meta;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : tsl_sync

// [tsl_top.sv]
/*
  Turn signal lamp logic: five active high switches in, six lamps out.
  Assumes switches are raw contacts, so each is synchronised first.
*/
`timescale 1ns/10ps
module tsl_top
  import tsl_pkg::*;
(
  input  wire logic clk,              // 10 MHz system clock
  input  wire logic rstn,             // Async active low reset
  input  wire logic left_turn,        // Turn lever down
  input  wire logic right_turn,       // Turn lever up
  input  wire logic brake,            // Brake pedal pressed
  input  wire logic hazard,           // Emergency switch on
  input  wire logic parking,          // Parking lights on
  output logic      left_front_lamp,  // Left front bulb
  output logic      right_front_lamp, // Right front bulb
  output logic      left_rear_lamp,   // Left rear bulb
  output logic      right_rear_lamp,  // Right rear bulb
  output logic      left_dash_lamp,   // Left dashboard indicator
  output logic      right_dash_lamp   // Right dashboard indicator
);
  import tsl_pkg::*;

  logic              rst_meta;
  logic              rst_n;
  logic [4:0]        raw_in;
  logic [4:0]        sync_in;
  logic [TICK_W-1:0] tick_cnt;
  logic [DIV_W-1:0]  sub_div;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign raw_in = {parking, hazard, brake, right_turn, left_turn};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      tsl_sync u_sync (
        .clk  (clk),
        .rstn (rst_n),
        .d    (raw_in[gi]),
        .q    (sync_in[gi])
      );
    end
  endgenerate

  wire s_left    = sync_in[0];
  wire s_right   = sync_in[1];
  wire s_brake   = sync_in[2];
  wire s_hazard  = sync_in[3];
  wire s_parking = sync_in[4];

  // Tick every 4.096 ms: about 244 updates per second, far above flicker
  wire tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  // Count down, reload at one: 244 ticks per slow period
  wire [DIV_W-1:0] next_sub_div = (sub_div <= 8'h01) ? DIV_RELOAD
                                                     : sub_div - 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sub_div <= DIV_RESET;
    else if (tick)
      sub_div <= next_sub_div;
  end

  wire fast_square_wave = sub_div[FAST_BIT];
  wire slow_square_wave = sub_div[SLOW_BIT];

  wire glow_term  = s_parking & fast_square_wave;
  // Turn or hazard selects the side, slow wave does the blinking
  wire left_sel   = s_left | s_hazard;
  wire right_sel  = s_right | s_hazard;
  wire left_blk   = left_sel & slow_square_wave;
  wire right_blk  = right_sel & slow_square_wave;
  // Brake steady on rear unless a turn goes toward that side
  wire left_stdy  = s_brake & ~s_left;
  wire right_stdy = s_brake & ~s_right;
  // Blink is masked off when steady, which also blocks hazard there
  wire next_lf = left_blk | glow_term;
  wire next_rf = right_blk | glow_term;
  wire next_lr = left_stdy | (left_blk & ~left_stdy) | glow_term;
  wire next_rr = right_stdy | (right_blk & ~right_stdy) | glow_term;
  wire next_ld = left_blk;
  wire next_rd = right_blk;

  // Outputs latch on each tick only, like a periodic software update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_front_lamp  <= 1'b0;
      right_front_lamp <= 1'b0;
      left_rear_lamp   <= 1'b0;
      right_rear_lamp  <= 1'b0;
      left_dash_lamp   <= 1'b0;
      right_dash_lamp  <= 1'b0;
    end
    else if (tick)
    begin
      left_front_lamp  <= next_lf;
      right_front_lamp <= next_rf;
      left_rear_lamp   <= next_lr;
      right_rear_lamp  <= next_rr;
      left_dash_lamp   <= next_ld;
      right_dash_lamp  <= next_rd;
    end
  end

  AST_DASH_NO_GLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !slow_square_wave) |=> (!left_dash_lamp && !right_dash_lamp))
    else $error("dash lamp lit while slow wave low");

  AST_BRAKE_STEADY: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_brake && !s_left) |=> left_rear_lamp)
    else $error("left rear not steady under brake");

  AST_TURN_BLINK_REAR: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_right && !s_parking) |=> (right_rear_lamp == $past(slow_square_wave)))
    else $error("right rear not following slow wave on turn");

  AST_FRONT_NO_BRAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !s_left && !s_hazard && !s_parking) |=> !left_front_lamp)
    else $error("left front lit without turn, hazard or parking");

  AST_HAZARD_FRONT: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_hazard && slow_square_wave) |=> (left_front_lamp && right_front_lamp))
    else $error("hazard did not light both fronts");

  AST_GLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_parking && fast_square_wave) |=> (left_rear_lamp && right_front_lamp))
    else $error("glow missing on exterior lamp");

  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(left_rear_lamp))
    else $error("lamp changed between ticks");

  AST_DIV_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && sub_div == 8'h01) |=> (sub_div == DIV_RELOAD))
    else $error("divider did not reload with 244");

  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick)
    else $error("tick too frequent");

  // Mirrors of the checks above for the other side or other lamps
  AST_LEFT_TURN_REAR: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_left && !s_parking) |=> (left_rear_lamp == $past(slow_square_wave)))
    else $error("left rear not following slow wave on turn");

  AST_TURN_DASH: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_right) |=> (right_dash_lamp == $past(slow_square_wave)))
    else $error("right dash not following slow wave on turn");

  AST_HAZARD_DASH: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_hazard && slow_square_wave) |=> (left_dash_lamp && right_dash_lamp))
    else $error("hazard did not light both dash lamps");

  AST_RIGHT_BRAKE_STEADY: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && s_brake && !s_right) |=> right_rear_lamp)
    else $error("right rear not steady under brake");

  AST_DASH_NO_BRAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !s_right && !s_hazard) |=> !right_dash_lamp)
    else $error("right dash lit without turn or hazard");

  AST_GLOW_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && glow_term) |=> (left_front_lamp && right_rear_lamp))
    else $error("glow missing on left front or right rear");

  AST_IDLE_DARK: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !s_left && !s_hazard && !s_brake && !s_parking) |=> !left_rear_lamp)
    else $error("left rear lit with all switches off");

  // Checked at release, so the reset branch itself is covered
  AST_RESET_DARK: assert property (@(posedge clk)
    $rose(rst_n) |-> (!left_front_lamp && !right_front_lamp && !left_rear_lamp
                      && !right_rear_lamp && !left_dash_lamp && !right_dash_lamp))
    else $error("lamp lit at reset release");

  AST_TICK_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> (tick_cnt == '0))
    else $error("tick counter did not wrap");
endmodule : tsl_top
